// ===== design/sxp_top.sv
`timescale 1ns/1ps
module sxp_top
  import sxp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  output logic tx_oe
);

  sxp_frame_if fr ();

  logic [SXP_CTRL_W-1:0] ctrl_r;
  logic [19:0] div_r;
  logic [7:0] hold_r;
  logic hold_v_r;
  logic hold_eos_r;
  logic suspend_r;
  logic [7:0] rdat_r;
  logic rvalid_r;
  logic par_err_r;
  logic frm_err_r;
  logic ovr_err_r;
  logic csum_pend_r;
  sxp_tx_state_e tx_st_r;
  sxp_tx_state_e tx_st_nxt;
  logic [19:0] bit_cnt_r;
  logic [3:0] tx_idx_r;
  logic [7:0] tx_shf_r;
  logic tx_par_r;
  logic tx_csum_r;

  logic rx_done;
  logic [7:0] rx_data;
  logic rx_par_err;
  logic rx_frm_err;
  logic [7:0] csum_val;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration to the receiver.
  assign fr.bits8 = ctrl_r[SXP_CTRL_BITS8];
  assign fr.par_en = ctrl_r[SXP_CTRL_PAR_EN];
  assign fr.par_odd = ctrl_r[SXP_CTRL_PAR_ODD];
  assign fr.div = div_r;

  sxp_rx u_rx (
    .clk(clk),
    .rst_b(rst_b),
    .cfg(fr),
    .rxd(rxd),
    .done(rx_done),
    .data(rx_data),
    .par_err(rx_par_err),
    .frm_err(rx_frm_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. The slave always answers in the access cycle, no wait states.
  logic acc;
  logic wr;
  logic rd;
  logic hit_ctrl;
  logic hit_baud;
  logic hit_txd;
  logic hit_rxd;
  logic hit_stat;
  logic mapped;
  logic [1:0] line_sel;
  logic cont_mode;
  logic is_stop;
  logic is_resume;
  logic flow_chr;
  logic bit_end;
  logic tx_load;
  logic [3:0] tx_nbits;
  logic [19:0] div_wr;
  logic [31:0] rd_mux;
  logic [31:0] stat_word;
  logic tx_busy;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign hit_ctrl = (paddr == SXP_OFF_CTRL);
  assign hit_baud = (paddr == SXP_OFF_BAUD);
  assign hit_txd = (paddr == SXP_OFF_TXD);
  assign hit_rxd = (paddr == SXP_OFF_RXD);
  assign hit_stat = (paddr == SXP_OFF_STAT);
  assign mapped = hit_ctrl || hit_baud || hit_txd || hit_rxd || hit_stat;
  assign line_sel = ctrl_r[SXP_CTRL_LINE_HI:SXP_CTRL_LINE_LO];
  assign cont_mode = ctrl_r[SXP_CTRL_CONT];

  // Divisor writes are clamped into the supported rate range.
  assign div_wr = (pwdata[19:0] > SXP_DIV_MAX) ? SXP_DIV_MAX :
                  (pwdata[19:0] < SXP_DIV_MIN) ? SXP_DIV_MIN : pwdata[19:0];

  assign tx_busy = (tx_st_r != SXP_TX_IDLE);
  assign stat_word = {25'h0000000, suspend_r, ovr_err_r, frm_err_r, par_err_r,
                      rvalid_r, hold_v_r, tx_busy};
  assign rd_mux = hit_ctrl ? {23'h000000, ctrl_r} :
                  hit_baud ? {12'h000, div_r} :
                  hit_txd ? {24'h000000, hold_r} :
                  hit_rxd ? {24'h000000, rdat_r} :
                  hit_stat ? stat_word : 32'h00000000;

  // Flow characters are caught here and kept out of the data path.
  assign is_stop = rx_done && (rx_data == SXP_CHR_STOP);
  assign is_resume = rx_done && (rx_data == SXP_CHR_RESUME);
  assign flow_chr = ctrl_r[SXP_CTRL_FLOW_EN] && (is_stop || is_resume);

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer registers.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Configuration registers, written only when the access completes.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_r <= SXP_CTRL_RST;
      div_r <= SXP_DIV_RST;
    end
    else if (wr && pready)
    begin
      if (hit_ctrl)
        ctrl_r <= pwdata[SXP_CTRL_W-1:0];
      if (hit_baud)
        div_r <= div_wr;
    end
  end

  // Transmit holding register. A write while full is dropped and software
  // must poll the full flag; this keeps the path to one character.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hold_r <= 8'h00;
      hold_v_r <= 1'b0;
      hold_eos_r <= 1'b0;
    end
    else if (wr && pready && hit_txd && !hold_v_r)
    begin
      hold_r <= pwdata[7:0];
      hold_v_r <= 1'b1;
      hold_eos_r <= pwdata[SXP_CTRL_EOS];
    end
    else if (tx_load && !csum_pend_r)
      hold_v_r <= 1'b0;
  end

  // Suspend flag: stop sets, resume clears, only while flow control is on; turning it off clears the flag.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      suspend_r <= 1'b0;
    else if (!ctrl_r[SXP_CTRL_FLOW_EN])
      suspend_r <= 1'b0;
    else if (is_stop)
      suspend_r <= 1'b1;
    else if (is_resume)
      suspend_r <= 1'b0;
  end

  // Receive data and sticky errors; a new event wins over a read clear.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdat_r <= 8'h00;
      rvalid_r <= 1'b0;
      par_err_r <= 1'b0;
      frm_err_r <= 1'b0;
      ovr_err_r <= 1'b0;
    end
    else
    begin
      if (rx_done && !flow_chr)
      begin
        rdat_r <= rx_data;
        rvalid_r <= 1'b1;
      end
      else if (rd && pready && hit_rxd)
        rvalid_r <= 1'b0;
      if (rx_done && !flow_chr && rvalid_r)
        ovr_err_r <= 1'b1;
      else if (wr && pready && hit_stat && pwdata[SXP_ST_OVR_ERR])
        ovr_err_r <= 1'b0;
      if (rx_done && rx_par_err)
        par_err_r <= 1'b1;
      else if (wr && pready && hit_stat && pwdata[SXP_ST_PAR_ERR])
        par_err_r <= 1'b0;
      if (rx_done && rx_frm_err)
        frm_err_r <= 1'b1;
      else if (wr && pready && hit_stat && pwdata[SXP_ST_FRM_ERR])
        frm_err_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Running checksum over continuous-mode characters.
  sxp_csum u_csum (
    .clk(clk),
    .rst_b(rst_b),
    .clr(tx_load && tx_csum_r),
    .add(tx_load && cont_mode && !csum_pend_r),
    .chr(hold_r),
    .sum(csum_val)
  );

  // A checksum is owed after the last character of a continuous string.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      csum_pend_r <= 1'b0;
    else if (tx_load && csum_pend_r)
      csum_pend_r <= 1'b0;
    else if (tx_load && cont_mode && hold_eos_r && ctrl_r[SXP_CTRL_CSUM_EN])
      csum_pend_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter. A character already on the line always finishes; suspend
  // only blocks the next one from starting.
  assign bit_end = (bit_cnt_r == div_r);
  assign tx_nbits = ctrl_r[SXP_CTRL_BITS8] ? 4'h8 : 4'h7;
  assign tx_load = (tx_st_r == SXP_TX_IDLE) && (hold_v_r || csum_pend_r) &&
                   !suspend_r;

  always_comb
  begin
    tx_st_nxt = tx_st_r;
    case (tx_st_r)
      SXP_TX_IDLE: if (tx_load) tx_st_nxt = SXP_TX_START;
      SXP_TX_START: if (bit_end) tx_st_nxt = SXP_TX_DATA;
      SXP_TX_DATA:
        if (bit_end && tx_idx_r == tx_nbits - 4'h1)
          tx_st_nxt = ctrl_r[SXP_CTRL_PAR_EN] ? SXP_TX_PAR : SXP_TX_STOP;
      SXP_TX_PAR: if (bit_end) tx_st_nxt = SXP_TX_STOP;
      SXP_TX_STOP: if (bit_end) tx_st_nxt = SXP_TX_IDLE;
      default: tx_st_nxt = SXP_TX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_st_r <= SXP_TX_IDLE;
      bit_cnt_r <= 20'h00000;
      tx_idx_r <= 4'h0;
      tx_shf_r <= 8'h00;
      tx_par_r <= 1'b0;
      tx_csum_r <= 1'b0;
    end
    else
    begin
      tx_st_r <= tx_st_nxt;
      bit_cnt_r <= (bit_end || tx_st_r == SXP_TX_IDLE) ? 20'h00000 : bit_cnt_r + 20'h00001;
      if (tx_load)
      begin
        tx_shf_r <= csum_pend_r ? csum_val : hold_r;
        tx_csum_r <= csum_pend_r;
        tx_idx_r <= 4'h0;
        tx_par_r <= ctrl_r[SXP_CTRL_PAR_ODD];
      end
      else if (tx_st_r == SXP_TX_DATA && bit_end)
      begin
        tx_idx_r <= tx_idx_r + 4'h1;
        tx_par_r <= tx_par_r ^ tx_shf_r[0];
        tx_shf_r <= {1'b0, tx_shf_r[7:1]};
      end
    end
  end

  // Line driver: single-ended has no enable pin in use, point-to-point
  // always drives, multi-drop drives only during a character.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      txd <= 1'b1;
      tx_oe <= 1'b0;
    end
    else
    begin
      case (tx_st_nxt)
        SXP_TX_START: txd <= 1'b0;
        SXP_TX_DATA: txd <= (tx_st_r == SXP_TX_DATA && bit_end) ? tx_shf_r[1] : tx_shf_r[0];
        SXP_TX_PAR: txd <= (tx_st_r == SXP_TX_DATA) ? tx_par_r ^ tx_shf_r[0] : tx_par_r;
        default: txd <= 1'b1;
      endcase
      case (line_sel)
        SXP_LINE_P2P: tx_oe <= 1'b1;
        SXP_LINE_MDROP: tx_oe <= (tx_st_nxt != SXP_TX_IDLE);
        default: tx_oe <= 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_SUSPEND_BLOCKS: assert property (@(posedge clk) disable iff (!rst_b)
    suspend_r && tx_st_r == SXP_TX_IDLE |=> tx_st_r == SXP_TX_IDLE)
    else $error("transmission started while suspended");
  AST_RESUME_CLEARS: assert property (@(posedge clk) disable iff (!rst_b)
    is_resume && !is_stop && ctrl_r[SXP_CTRL_FLOW_EN] |=> !suspend_r)
    else $error("resume character did not clear suspend");
  AST_P2P_DRIVE: assert property (@(posedge clk) disable iff (!rst_b)
    $past(line_sel) == SXP_LINE_P2P |-> tx_oe)
    else $error("point-to-point driver released");
  AST_MDROP_RELEASE: assert property (@(posedge clk) disable iff (!rst_b)
    line_sel == SXP_LINE_MDROP && tx_st_r == SXP_TX_IDLE && $stable(line_sel) |-> !tx_oe)
    else $error("multi-drop driver on while idle");
  AST_FLOW_NOT_DATA: assert property (@(posedge clk) disable iff (!rst_b)
    flow_chr && !rvalid_r |=> !rvalid_r)
    else $error("flow character delivered as data");
  AST_START_LOW: assert property (@(posedge clk) disable iff (!rst_b)
    tx_load |=> tx_st_r == SXP_TX_START ##1 !txd)
    else $error("start bit not low");
  AST_STOP_HIGH: assert property (@(posedge clk) disable iff (!rst_b)
    tx_st_r == SXP_TX_STOP |-> txd)
    else $error("stop bit not high");
  AST_DIV_RANGE: assert property (@(posedge clk) disable iff (!rst_b)
    div_r >= SXP_DIV_MIN && div_r <= SXP_DIV_MAX)
    else $error("bit divisor out of range");

endmodule

// ===== design/sxp_pkg.sv
package sxp_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] SXP_OFF_CTRL = 8'h00;
  localparam logic [7:0] SXP_OFF_BAUD = 8'h04;
  localparam logic [7:0] SXP_OFF_TXD = 8'h08;
  localparam logic [7:0] SXP_OFF_RXD = 8'h0C;
  localparam logic [7:0] SXP_OFF_STAT = 8'h10;

  // Control register field positions.
  localparam int SXP_CTRL_BITS8 = 0;
  localparam int SXP_CTRL_PAR_EN = 1;
  localparam int SXP_CTRL_PAR_ODD = 2;
  localparam int SXP_CTRL_LINE_LO = 3;
  localparam int SXP_CTRL_LINE_HI = 4;
  localparam int SXP_CTRL_CONT = 5;
  localparam int SXP_CTRL_CSUM_EN = 6;
  localparam int SXP_CTRL_EOS = 7;
  localparam int SXP_CTRL_FLOW_EN = 8;
  localparam int SXP_CTRL_W = 9;

  // Status register field positions.
  localparam int SXP_ST_TX_BUSY = 0;
  localparam int SXP_ST_TX_FULL = 1;
  localparam int SXP_ST_RX_VALID = 2;
  localparam int SXP_ST_PAR_ERR = 3;
  localparam int SXP_ST_FRM_ERR = 4;
  localparam int SXP_ST_OVR_ERR = 5;
  localparam int SXP_ST_SUSPEND = 6;

  // Reset values: 8 data bits, no parity, single-ended, flow control on.
  localparam logic [8:0] SXP_CTRL_RST = 9'h101;

  // Line interface selection.
  localparam logic [1:0] SXP_LINE_SE = 2'h0;
  localparam logic [1:0] SXP_LINE_P2P = 2'h1;
  localparam logic [1:0] SXP_LINE_MDROP = 2'h2;

  // Flow control characters.
  localparam logic [7:0] SXP_CHR_STOP = 8'h13;
  localparam logic [7:0] SXP_CHR_RESUME = 8'h11;

  // Bit timing: one bit period is (divisor + 1) clocks, 16x oversampled on receive.
  localparam int SXP_CLK_HZ = 250000000;
  localparam int SXP_BAUD_MIN = 300;
  localparam int SXP_BAUD_MAX = 115200;
  localparam int SXP_OVS = 16;
  localparam logic [19:0] SXP_DIV_MAX = 20'((SXP_CLK_HZ / SXP_BAUD_MIN) - 1);
  localparam logic [19:0] SXP_DIV_MIN = 20'((SXP_CLK_HZ / SXP_BAUD_MAX) - 1);
  localparam logic [19:0] SXP_DIV_RST = 20'((SXP_CLK_HZ / 9600) - 1);

  // Transmitter states.
  typedef enum logic [4:0]
  {
    SXP_TX_IDLE = 5'h01,
    SXP_TX_START = 5'h02,
    SXP_TX_DATA = 5'h04,
    SXP_TX_PAR = 5'h08,
    SXP_TX_STOP = 5'h10
  } sxp_tx_state_e;

endpackage

// ===== design/sxp_frame_if.sv
`timescale 1ns/1ps
// Framing settings and the shared bit divisor, passed from the top to the receiver.
interface sxp_frame_if;
  logic bits8;
  logic par_en;
  logic par_odd;
  logic [19:0] div;
  modport cfg (output bits8, output par_en, output par_odd, output div);
  modport use_cfg (input bits8, input par_en, input par_odd, input div);
endinterface

// ===== design/sxp_rx.sv
`timescale 1ns/1ps
module sxp_rx
  import sxp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  sxp_frame_if.use_cfg cfg,
  input wire logic rxd,
  output logic done,
  output logic [7:0] data,
  output logic par_err,
  output logic frm_err
);

  logic [15:0] tick_cnt_r;
  logic [3:0] ovs_cnt_r;
  logic [3:0] bit_idx_r;
  logic [9:0] shf_r;
  logic busy_r;
  logic rxd_q_r;
  logic rx_s_r;
  logic [15:0] tick_div;
  logic tick;
  logic mid;
  logic [3:0] nbits;
  logic last;
  logic par_calc;

  ////////////////////////////////////////////////////////////////////////////
  // Oversample tick is one sixteenth of a bit; input is synchronous already.
  assign tick_div = cfg.div[19:4];
  assign tick = (tick_cnt_r == tick_div);
  assign mid = tick && (ovs_cnt_r == 4'h7);
  // Start, data, optional parity, stop.
  assign nbits = 4'h1 + (cfg.bits8 ? 4'h8 : 4'h7) + {3'h0, cfg.par_en} + 4'h1;
  assign last = mid && (bit_idx_r == nbits - 4'h1);
  // With parity the parity bit sits at [8], so data plus parity is [8:0] or [8:1].
  assign par_calc = (cfg.bits8 ? ^shf_r[8:0] : ^shf_r[8:1]) ^ cfg.par_odd;

  // Bit counter and shifter; samples each bit at its centre.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_cnt_r <= 16'h0000;
      ovs_cnt_r <= 4'h0;
      bit_idx_r <= 4'h0;
      shf_r <= 10'h000;
      busy_r <= 1'b0;
      rxd_q_r <= 1'b1;
    end
    else
    begin
      rxd_q_r <= rxd;
      tick_cnt_r <= (tick || !busy_r) ? 16'h0000 : tick_cnt_r + 16'h0001;
      if (!busy_r)
      begin
        ovs_cnt_r <= 4'h0;
        bit_idx_r <= 4'h0;
        busy_r <= rxd_q_r && !rxd;
      end
      else
      begin
        if (tick)
          ovs_cnt_r <= ovs_cnt_r + 4'h1;
        if (mid)
        begin
          bit_idx_r <= bit_idx_r + 4'h1;
          shf_r <= {rxd, shf_r[9:1]};
          if (bit_idx_r == 4'h0 && rxd)
            busy_r <= 1'b0;
        end
        if (last)
          busy_r <= 1'b0;
      end
    end
  end

  // On completion the data bits are taken from [7:0], [7:1], [8:1] or [8:2] by format.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      done <= 1'b0;
      data <= 8'h00;
      par_err <= 1'b0;
      frm_err <= 1'b0;
      rx_s_r <= 1'b0;
    end
    else
    begin
      rx_s_r <= last;
      done <= rx_s_r;
      if (rx_s_r)
      begin
        // Shifted value holds stop at [9]; parity, if any, at [8].
        data <= cfg.par_en ? (cfg.bits8 ? shf_r[7:0] : {1'b0, shf_r[7:1]})
                           : (cfg.bits8 ? shf_r[8:1] : {1'b0, shf_r[8:2]});
        frm_err <= !shf_r[9];
        par_err <= cfg.par_en && par_calc;
      end
    end
  end

endmodule

// ===== design/sxp_csum.sv
`timescale 1ns/1ps
// Running two's-complement checksum of a continuous output string.
module sxp_csum
  import sxp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic add,
  input wire logic [7:0] chr,
  output logic [7:0] sum
);

  logic [7:0] acc_r;

  // The sum is negated and cut to seven bits so it stays printable-safe.
  assign sum = 8'((~acc_r + 8'h01) & 8'h7F);

  // A string that starts just after a checksum must still count its first character.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      acc_r <= 8'h00;
    else if (clr)
      acc_r <= add ? chr : 8'h00;
    else if (add)
      acc_r <= 8'(acc_r + chr);
  end

endmodule

// ===== dv/sxp_peer.sv
`timescale 1ns/1ps
// Far-side serial device: it captures what the port sends and answers with flow characters.
module sxp_peer
#(
  parameter int BIT_CLKS = 2170
)
(
  input wire logic clk,
  input wire logic line_in,
  output logic rxd
);
  logic [9:0] last_frame;
  int frame_cnt;
  int i;

  ////////////////////////////////////////////////////////////////////////////////
  // The link rests at mark until this device sends anything.
  initial
  begin
    rxd = 1'b1;
    frame_cnt = 0;
    last_frame = '0;
  end

  // Ten bits are sampled mid-bit, lsb first, so one capture fits 8N1 and 7E1 alike.
  // It stops at the centre of the stop bit so a frame sent right after is not missed.
  always
  begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (i = 0; i < 10; i++)
    begin
      last_frame[i] = line_in;
      if (i < 9)
        repeat (BIT_CLKS) @(posedge clk);
    end
    frame_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sends one raw frame, lsb first; the stop bit leaves the line at mark.
  task automatic send_frm(input logic [9:0] frm);
    for (int k = 0; k < 10; k++)
    begin
      @(posedge clk);
      rxd <= frm[k];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
  endtask
endmodule

// ===== dv/tb_sxp_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end

module tb_sxp_top;
  import sxp_pkg::*;
  // The fastest clamped rate keeps each character near 22000 clocks.
  localparam int BITC = 2170;
  logic clk, rst_b, psel, penable, pwrite, rxd, txd, tx_oe, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int error_cnt, cmp_count, n, k;
  wire line_w;

  ////////////////////////////////////////////////////////////////////////////////
  // A released multi-drop line is held at mark by its bias network.
  assign line_w = tx_oe ? txd : 1'b1;

  sxp_top sxp_top_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_oe(tx_oe));

  sxp_peer #(.BIT_CLKS(BITC)) sxp_peer_inst (.clk(clk), .line_in(line_w), .rxd(rxd));

  // Free-running 250 MHz clock.
  initial clk = 1'b0;
  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; an idle cycle follows so no signal is driven twice in one step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    w = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && w < 100)
    begin
      @(posedge clk);
      w++;
    end
    if (w >= 100)
      error_cnt++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Waits, bounded, for the peer to log another frame.
  task automatic wait_frm(input int c0);
    k = 0;
    while (sxp_peer_inst.frame_cnt == c0 && k < 30000)
    begin
      @(posedge clk);
      k++;
    end
    if (sxp_peer_inst.frame_cnt == c0)
      error_cnt++;
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // The tests need about 90000 clocks; a hang past that ends the run as a failure.
  initial
  begin
    repeat (98000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: registers, a plain frame, then suspend in point-to-point mode and resume in multi-drop mode.
  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    `CHK("txd in reset", 1'b1, txd)
    `CHK("oe in reset", 1'b0, tx_oe)
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("oe single ended", 1'b1, tx_oe)
    apb(1'b0, SXP_OFF_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h00000101, rd)
    apb(1'b0, SXP_OFF_BAUD, 32'h0);
    `CHK("baud reset", 32'h000065B8, rd)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b1, SXP_OFF_BAUD, 32'h000FFFFF);
    apb(1'b0, SXP_OFF_BAUD, 32'h0);
    `CHK("baud slowest", 32'h000CB734, rd)
    apb(1'b1, SXP_OFF_BAUD, 32'h0);
    apb(1'b0, SXP_OFF_BAUD, 32'h0);
    `CHK("baud fastest", 32'h00000879, rd)
    // Point-to-point, 8N1: the driver stays on around the frame.
    apb(1'b1, SXP_OFF_CTRL, 32'h00000109);
    repeat (3) @(posedge clk);
    `CHK("oe p2p idle", 1'b1, tx_oe)
    n = sxp_peer_inst.frame_cnt;
    apb(1'b1, SXP_OFF_TXD, 32'h00000041);
    wait_frm(n);
    `CHK("frame 8n1", 10'h282, sxp_peer_inst.last_frame)
    `CHK("oe p2p after", 1'b1, tx_oe)
    // Stop character arrives; it must be swallowed and must hold the next character.
    sxp_peer_inst.send_frm(10'h226);
    repeat (20) @(posedge clk);
    apb(1'b0, SXP_OFF_STAT, 32'h0);
    `CHK("suspended", 1'b1, rd[SXP_ST_SUSPEND])
    `CHK("stop not data", 1'b0, rd[SXP_ST_RX_VALID])
    apb(1'b1, SXP_OFF_CTRL, 32'h00000112);
    repeat (3) @(posedge clk);
    `CHK("oe mdrop idle", 1'b0, tx_oe)
    n = sxp_peer_inst.frame_cnt;
    apb(1'b1, SXP_OFF_TXD, 32'h00000055);
    repeat (2 * BITC) @(posedge clk);
    `CHK("held frames", n, sxp_peer_inst.frame_cnt)
    `CHK("held line", 1'b1, txd)
    apb(1'b0, SXP_OFF_STAT, 32'h0);
    `CHK("held full", 1'b1, rd[SXP_ST_TX_FULL])
    `CHK("held idle", 1'b0, rd[SXP_ST_TX_BUSY])
    apb(1'b1, SXP_OFF_TXD, 32'h00000077);
    apb(1'b0, SXP_OFF_TXD, 32'h0);
    `CHK("full write dropped", 32'h00000055, rd)
    // Resume character in 7E1 releases the held character.
    sxp_peer_inst.send_frm(10'h222);
    k = 0;
    while (txd !== 1'b0 && k < 30000)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 30000)
      error_cnt++;
    repeat (5) @(posedge clk);
    `CHK("oe mdrop busy", 1'b1, tx_oe)
    wait_frm(n);
    `CHK("frame 7e1", 10'h2AA, sxp_peer_inst.last_frame)
    repeat (BITC) @(posedge clk);
    `CHK("oe mdrop after", 1'b0, tx_oe)
    apb(1'b0, SXP_OFF_STAT, 32'h0);
    `CHK("resumed", 1'b0, rd[SXP_ST_SUSPEND])
    `CHK("resume not data", 1'b0, rd[SXP_ST_RX_VALID])
    `CHK("no line errors", 3'b000, rd[SXP_ST_OVR_ERR:SXP_ST_PAR_ERR])
    apb(1'b0, SXP_OFF_RXD, 32'h0);
    `CHK("rx data untouched", 32'h00000000, rd)
    give_verdict();
  end
endmodule
